// ---- design/aoc_pkg.sv ----
// Package for the per-channel offset and gain calibration stage.
// Assumes a byte-indexed register port; multi-byte trims are words here.
package aoc_pkg;
  localparam int unsigned DATA_W = 24;
  localparam int unsigned REG_AW = 8;
  localparam int unsigned REG_DW = 24;
  // Register offsets as printed
  localparam logic [7:0] OFF_OFFSET_CH0 = 8'h0e;
  localparam logic [7:0] OFF_GAIN_CH0 = 8'h11;
  localparam logic [7:0] OFF_OFFSET_CH1 = 8'h14;
  localparam logic [7:0] OFF_GAIN_CH1 = 8'h17;
  localparam logic [7:0] OFF_REF_TRIM = 8'h1a;
  // Control and status word placed beside the trims
  localparam logic [7:0] OFF_CTRL = 8'h20;
  localparam logic [7:0] OFF_STATUS = 8'h21;
  localparam int unsigned CTRL_OFFSET_EN_BIT = 0;
  localparam int unsigned CTRL_GAIN_EN_BIT = 1;
  localparam logic [23:0] TRIM_RST = 24'h000000;
  localparam logic [7:0] REF_TRIM_RST = 8'h42;
  localparam int unsigned GAIN_FRAC_BITS = 23;
  localparam logic [23:0] OUT_MAX = 24'h7fffff;
  localparam logic [23:0] OUT_MIN = 24'h800000;
  // Gain correction latency in master clock periods
  localparam int unsigned GAIN_DELAY_CYC = 24;
  localparam int unsigned FIFO_DEPTH = 16;
endpackage : aoc_pkg

// ---- design/aoc_fifo.sv ----
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; push and pop may occur in the same cycle.
`timescale 1ns/1ns
module aoc_fifo #(
  parameter int unsigned WIDTH = 25,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk, // Clock
  input wire logic rst, // Async reset, active high
  input wire logic in_valid, // Write request
  output logic in_ready, // Space available
  input wire logic [WIDTH-1:0] in_data, // Write data
  output logic out_valid, // Data available
  input wire logic out_ready, // Consumer accepts
  output logic [WIDTH-1:0] out_data // Head word
);
  localparam int unsigned AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("DEPTH must be a power of two >= 2");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_q, rd_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign out_data = mem[rd_q[AW-1:0]];
  always_ff @(posedge clk) begin
    if (push) mem[wr_q[AW-1:0]] <= in_data;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
    end
  end
endmodule : aoc_fifo

// ---- design/aoc_delay.sv ----
// Fixed-length shift delay for a valid flag and a word.
// Assumes single clock; zero-length delay is not supported.
`timescale 1ns/1ns
module aoc_delay #(
  parameter int unsigned WIDTH = 25,
  parameter int unsigned STAGES = 24
) (
  input wire logic clk, // Clock
  input wire logic rst, // Async reset, active high
  input wire logic [WIDTH-1:0] din, // Input word
  output logic [WIDTH-1:0] dout // Word STAGES cycles later
);
  if (STAGES < 1) begin : g_bad_stages
    $error("STAGES must be at least 1");
  end
  logic [WIDTH-1:0] pipe_q [STAGES];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < STAGES; i++) pipe_q[i] <= '0;
    end else begin
      pipe_q[0] <= din;
      for (int i = 1; i < STAGES; i++) pipe_q[i] <= pipe_q[i-1];
    end
  end
  assign dout = pipe_q[STAGES-1];
endmodule : aoc_delay

// ---- design/aoc_calib.sv ----
// Offset and gain calibration stage for two converter channels.
// Assumes raw samples arrive as one-cycle strobes on the master clock and
// software uses the plain register port with read data one cycle later.
`timescale 1ns/1ns
// Summary of operation
// - With offset correction on, each channel output is its raw code plus its offset trim.
// - Offset trims are 24-bit two's complement values.
// - A disabled correction ignores its trim but never alters the stored trim.
// - Gain trims are signed 24-bit fractions from -1 to 0x7fffff.
// - With gain on, the offset-corrected code is multiplied by trim plus one.
// - The effective multiplier therefore spans zero to just under two.
// - One gain trim step moves the multiplier by two to the minus 23.
// - Each channel has its own offset trim applied only to that channel.
// - Each channel has its own gain trim applied only to that channel.
// - An 8-bit read/write reference trim resets to 0x42.
// - Offset correction adds no delay to data or data-ready.
// - Gain correction delays data and data-ready of both channels by 24 clocks.
module aoc_calib
  import aoc_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH_P = FIFO_DEPTH
) (
  input wire logic core_clk, // Digital master clock
  input wire logic rst, // Async reset, active high
  input wire logic [REG_AW-1:0] reg_addr, // Register address
  input wire logic [REG_DW-1:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [REG_DW-1:0] reg_rdata, // Read data, cycle after strobe
  input wire logic raw_valid0, // Channel 0 sample strobe
  input wire logic [DATA_W-1:0] raw_data0, // Channel 0 raw code
  input wire logic raw_valid1, // Channel 1 sample strobe
  input wire logic [DATA_W-1:0] raw_data1, // Channel 1 raw code
  output logic out_valid, // Corrected sample valid
  output logic out_chan, // Channel of the sample
  output logic [DATA_W-1:0] out_data, // Corrected code
  input wire logic out_ready, // Consumer accepts
  output logic drop_q // Sticky: sample lost on full FIFO
);
  if (FIFO_DEPTH_P < 2) begin : g_bad_depth
    $error("FIFO depth too small");
  end

  logic [23:0] offset_trim_ch0_q, offset_trim_ch1_q, gain_trim_ch0_q, gain_trim_ch1_q;
  logic [7:0] reference_temp_trim_q;
  logic offset_correction_enable_q, gain_correction_enable_q;
  logic [REG_DW-1:0] rdata_q;

  // Register decode
  wire sel_off0 = reg_addr == OFF_OFFSET_CH0;
  wire sel_off1 = reg_addr == OFF_OFFSET_CH1;
  wire sel_gain0 = reg_addr == OFF_GAIN_CH0;
  wire sel_gain1 = reg_addr == OFF_GAIN_CH1;
  wire sel_ref = reg_addr == OFF_REF_TRIM;
  wire sel_ctrl = reg_addr == OFF_CTRL;
  wire sel_stat = reg_addr == OFF_STATUS;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      offset_trim_ch0_q <= TRIM_RST;
      offset_trim_ch1_q <= TRIM_RST;
      gain_trim_ch0_q <= TRIM_RST;
      gain_trim_ch1_q <= TRIM_RST;
      reference_temp_trim_q <= REF_TRIM_RST;
      offset_correction_enable_q <= 1'b0;
      gain_correction_enable_q <= 1'b0;
    end else if (reg_wr) begin
      // Enable writes touch only the ctrl word, trims survive
      if (sel_off0) offset_trim_ch0_q <= reg_wdata;
      if (sel_off1) offset_trim_ch1_q <= reg_wdata;
      if (sel_gain0) gain_trim_ch0_q <= reg_wdata;
      if (sel_gain1) gain_trim_ch1_q <= reg_wdata;
      if (sel_ref) reference_temp_trim_q <= reg_wdata[7:0];
      if (sel_ctrl) begin
        offset_correction_enable_q <= reg_wdata[CTRL_OFFSET_EN_BIT];
        gain_correction_enable_q <= reg_wdata[CTRL_GAIN_EN_BIT];
      end
    end
  end

  wire [23:0] rd_mux =
    sel_off0 ? offset_trim_ch0_q :
    sel_off1 ? offset_trim_ch1_q :
    sel_gain0 ? gain_trim_ch0_q :
    sel_gain1 ? gain_trim_ch1_q :
    sel_ref ? {16'h0000, reference_temp_trim_q} :
    sel_ctrl ? {22'h000000, gain_correction_enable_q, offset_correction_enable_q} :
    sel_stat ? {23'h000000, drop_q} : 24'h000000;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) rdata_q <= '0;
    else if (reg_rd) rdata_q <= rd_mux;
    else rdata_q <= '0;
  end
  assign reg_rdata = rdata_q;

  // Offset stage: combinational, so no latency is added. Channel 1 waits
  // one cycle if both strobe together; a collision needs a queue slot.
  logic pend1_q;
  logic [23:0] pend1_data_q;
  wire take0 = raw_valid0;
  wire take1 = !raw_valid0 && (raw_valid1 || pend1_q);
  wire [23:0] ch1_raw = pend1_q ? pend1_data_q : raw_data1;
  wire in_valid = take0 || take1;
  wire in_chan = !take0;
  wire [23:0] sel_raw = take0 ? raw_data0 : ch1_raw;
  wire [23:0] sel_off = take0 ? offset_trim_ch0_q : offset_trim_ch1_q;
  wire [23:0] sel_gain = take0 ? gain_trim_ch0_q : gain_trim_ch1_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pend1_q <= 1'b0;
      pend1_data_q <= '0;
    end else if (raw_valid0 && raw_valid1) begin
      pend1_q <= 1'b1;
      pend1_data_q <= raw_data1;
    end else if (take1) begin
      pend1_q <= 1'b0;
    end
  end

  // Two's complement add, 25-bit sum then clip
  wire signed [24:0] off_sum = $signed({sel_raw[23], sel_raw}) + $signed({sel_off[23], sel_off});
  wire [23:0] off_sat =
    (off_sum[24] != off_sum[23]) ? (off_sum[24] ? OUT_MIN : OUT_MAX) : off_sum[23:0];
  wire [23:0] off_code = offset_correction_enable_q ? off_sat : sel_raw;

  // Gain stage: multiplier is 1 + trim/2^23, range 0 .. just under 2
  wire signed [25:0] gain_mul = 26'sd1 <<< GAIN_FRAC_BITS;
  wire signed [25:0] mult = gain_mul + 26'($signed(sel_gain));
  wire signed [49:0] prod = 50'($signed(off_code)) * 50'(mult);
  wire signed [49:0] scaled = prod >>> GAIN_FRAC_BITS;
  wire over_hi = !scaled[49] && (scaled[48:23] != 26'h0000000);
  wire under_lo = scaled[49] && (scaled[48:23] != 26'h3ffffff);
  wire [23:0] gain_sat = over_hi ? OUT_MAX : under_lo ? OUT_MIN : scaled[23:0];

  // Gain path latency: sample, channel and valid travel the delay line
  logic [25:0] dly_out;
  aoc_delay #(.WIDTH(26), .STAGES(GAIN_DELAY_CYC)) u_gain_dly (
    .clk(core_clk),
    .rst(rst),
    .din({in_valid && gain_correction_enable_q, in_chan, gain_sat}),
    .dout(dly_out)
  );

  // Direct path has no delay; the delayed path wins when both land in a cycle
  // just after the gain enable is cleared, and the direct sample is then counted lost.
  wire direct_v = in_valid && !gain_correction_enable_q;
  wire push_v = dly_out[25] || direct_v;
  wire [24:0] push_w = dly_out[25] ? dly_out[24:0] : {in_chan, off_code};
  wire push_collide = dly_out[25] && direct_v;

  logic fifo_in_ready, fifo_out_valid;
  logic [24:0] fifo_out_data;
  // Output register state is declared here so the FIFO pop can see it
  logic ov_q, oc_q;
  logic [23:0] od_q;
  wire out_pop = fifo_out_valid && (!ov_q || out_ready);
  aoc_fifo #(.WIDTH(25), .DEPTH(FIFO_DEPTH_P)) u_fifo (
    .clk(core_clk),
    .rst(rst),
    .in_valid(push_v),
    .in_ready(fifo_in_ready),
    .in_data(push_w),
    .out_valid(fifo_out_valid),
    .out_ready(out_pop),
    .out_data(fifo_out_data)
  );

  // Output register stage fed from the FIFO
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ov_q <= 1'b0;
      oc_q <= 1'b0;
      od_q <= '0;
    end else if (!ov_q || out_ready) begin
      ov_q <= fifo_out_valid;
      oc_q <= fifo_out_data[24];
      od_q <= fifo_out_data[23:0];
    end
  end
  assign out_valid = ov_q;
  assign out_chan = oc_q;
  assign out_data = od_q;

  // Converter cannot be stalled, so overflow is flagged; set beats read-clear
  wire lost = (push_v && !fifo_in_ready) || push_collide;
  logic drop_d;
  assign drop_d = lost ? 1'b1 : ((reg_rd && sel_stat) ? 1'b0 : drop_q);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) drop_q <= 1'b0;
    else drop_q <= drop_d;
  end

  // Checks
  chk_trim_hold: assert property (@(posedge core_clk) disable iff (rst)
    $rose(offset_correction_enable_q) || $fell(offset_correction_enable_q)
      |-> $stable(offset_trim_ch0_q) && $stable(offset_trim_ch1_q))
    else $error("offset trim changed with enable");
  chk_ref_reset: assert property (@(posedge core_clk)
    $fell(rst) |-> reference_temp_trim_q == 8'h42)
    else $error("reference trim reset value wrong");
  chk_off_sum: assert property (@(posedge core_clk) disable iff (rst)
    in_valid && offset_correction_enable_q && take0 && off_sum[24] == off_sum[23]
      |-> off_code == 24'(raw_data0 + offset_trim_ch0_q))
    else $error("offset sum wrong");
  chk_off_bypass: assert property (@(posedge core_clk) disable iff (rst)
    in_valid && !offset_correction_enable_q |-> off_code == sel_raw)
    else $error("offset bypass wrong");
  chk_clip_high: assert property (@(posedge core_clk) disable iff (rst)
    !sel_raw[23] && !sel_off[23] && off_sum[23] && offset_correction_enable_q
      |-> off_code == 24'h7fffff)
    else $error("offset did not clip high");
  chk_unity_gain: assert property (@(posedge core_clk) disable iff (rst)
    sel_gain == 24'h000000 |-> gain_sat == off_code)
    else $error("unity gain altered code");
  chk_zero_gain: assert property (@(posedge core_clk) disable iff (rst)
    sel_gain == 24'h800000 |-> gain_sat == 24'h000000)
    else $error("minus one trim not zero multiplier");
  sequence s_gain_in;
    in_valid && gain_correction_enable_q;
  endsequence
  chk_gain_delay: assert property (@(posedge core_clk) disable iff (rst)
    s_gain_in |-> ##24 (push_v && push_w[23:0] == $past(gain_sat, 24)))
    else $error("gain path delay not 24 cycles");
  chk_direct_push: assert property (@(posedge core_clk) disable iff (rst)
    direct_v && !dly_out[25] |-> push_v && push_w[23:0] == off_code)
    else $error("direct sample not pushed same cycle");
endmodule : aoc_calib

// ---- bench/aoc_src_model.sv ----
// Sample source standing in for the two decimation filter outputs.
// Assumes bench requests change by non-blocking assignment on core_clk.
`timescale 1ns/1ns
module aoc_src_model
  import aoc_pkg::*;
(
  input wire logic core_clk, // Master clock
  input wire logic rst, // Async reset, active high
  input wire logic req0, // Issue a channel 0 sample
  input wire logic req1, // Issue a channel 1 sample
  input wire logic [DATA_W-1:0] code0, // Channel 0 code
  input wire logic [DATA_W-1:0] code1, // Channel 1 code
  output logic raw_valid0, // Channel 0 strobe
  output logic [DATA_W-1:0] raw_data0, // Channel 0 data
  output logic raw_valid1, // Channel 1 strobe
  output logic [DATA_W-1:0] raw_data1 // Channel 1 data
);
  logic [DATA_W-1:0] last0_q;
  logic [DATA_W-1:0] last1_q;
  assign raw_valid0 = req0;
  assign raw_valid1 = req1;
  // Outside a strobe each data line shows the inverse of its own value in the previous cycle, so it toggles
  assign raw_data0 = req0 ? code0 : ~last0_q;
  assign raw_data1 = req1 ? code1 : ~last1_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      last0_q <= '0;
      last1_q <= '0;
    end else begin
      last0_q <= raw_data0;
      last1_q <= raw_data1;
    end
  end
endmodule : aoc_src_model

// ---- bench/tb.sv ----
// Self-checking bench for the two-channel offset and gain calibration stage.
// Assumes the design package and the source model are compiled first.
`timescale 1ns/1ns
module tb;
  import aoc_pkg::*;
  typedef struct packed {
    logic [1:0] ctrl;
    logic ch;
    logic [23:0] raw;
    logic [23:0] exp;
  } aoc_row_s;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [REG_AW-1:0] reg_addr = '0;
  logic [REG_DW-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [REG_DW-1:0] reg_rdata;
  logic req0 = 1'b0;
  logic req1 = 1'b0;
  logic [DATA_W-1:0] code0 = '0;
  logic [DATA_W-1:0] code1 = '0;
  logic raw_valid0;
  logic raw_valid1;
  logic [DATA_W-1:0] raw_data0;
  logic [DATA_W-1:0] raw_data1;
  logic out_valid;
  logic out_chan;
  logic drop_q;
  logic [DATA_W-1:0] out_data;
  logic out_ready = 1'b1;
  int err_total = 0;
  int n_tests = 0;
  int cycles = 0;
  int lat;
  logic [24:0] got_q[$];
  // Trims: offset 3 and -5, gain 1.5x and just under 2x
  aoc_row_s rows [11] = '{
    '{2'h0, 1'h0, 24'h000005, 24'h000005},
    '{2'h1, 1'h0, 24'h000005, 24'h000008},
    '{2'h1, 1'h1, 24'h000005, 24'h000000},
    '{2'h1, 1'h0, 24'h7ffffe, 24'h7fffff},
    '{2'h1, 1'h1, 24'h800002, 24'h800000},
    '{2'h2, 1'h0, 24'h000100, 24'h000180},
    '{2'h2, 1'h1, 24'h000100, 24'h0001ff},
    '{2'h3, 1'h0, 24'h000005, 24'h00000c},
    '{2'h2, 1'h1, 24'h400001, 24'h7fffff},
    '{2'h2, 1'h0, 24'hfffff0, 24'hffffe8},
    '{2'h0, 1'h1, 24'h400001, 24'h400001}
  };
  always #25 core_clk = ~core_clk;
  aoc_src_model aoc_src_model_inst (.core_clk(core_clk), .rst(rst), .req0(req0), .req1(req1),
    .code0(code0), .code1(code1), .raw_valid0(raw_valid0), .raw_data0(raw_data0),
    .raw_valid1(raw_valid1), .raw_data1(raw_data1));
  aoc_calib #(.FIFO_DEPTH_P(FIFO_DEPTH)) aoc_calib_inst (.core_clk(core_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .raw_valid0(raw_valid0), .raw_data0(raw_data0),
    .raw_valid1(raw_valid1), .raw_data1(raw_data1), .out_valid(out_valid),
    .out_chan(out_chan), .out_data(out_data), .out_ready(out_ready), .drop_q(drop_q));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test
  // Well above the few hundred cycles the sequence needs
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      err_total = err_total + 1;
      stop_test();
    end
  end
  task automatic check(input string what, input logic [24:0] exp, input logic [24:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask : check
  task automatic reg_write(input logic [7:0] a, input logic [23:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic check_reg(input logic [7:0] a, input logic [23:0] exp, input string what);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    check(what, {1'b0, exp}, {1'b0, reg_rdata});
  endtask : check_reg
  task automatic check_resets();
    check_reg(OFF_OFFSET_CH0, TRIM_RST, "offset ch0 reset");
    check_reg(OFF_GAIN_CH0, TRIM_RST, "gain ch0 reset");
    check_reg(OFF_OFFSET_CH1, TRIM_RST, "offset ch1 reset");
    check_reg(OFF_GAIN_CH1, TRIM_RST, "gain ch1 reset");
    check_reg(OFF_REF_TRIM, 24'h000042, "ref trim reset");
    check_reg(OFF_CTRL, 24'h000000, "ctrl reset");
  endtask : check_resets
  // Returns edges counted from the drive edge to the one that samples out_valid
  task automatic send(input logic ch, input logic [23:0] v, output int n);
    @(posedge core_clk);
    req0 <= ~ch;
    req1 <= ch;
    code0 <= v;
    code1 <= v;
    @(posedge core_clk);
    req0 <= 1'b0;
    req1 <= 1'b0;
    n = 1;
    while (out_valid !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
  endtask : send
  task automatic collect(input int n_cyc);
    for (int k = 0; k < n_cyc; k++) begin
      @(posedge core_clk);
      if (out_valid === 1'b1 && out_ready === 1'b1) got_q.push_back({out_chan, out_data});
      out_ready <= 1'(k % 2) | req0;
    end
  endtask : collect
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    check_resets();
    reg_write(OFF_OFFSET_CH0, 24'h000003);
    reg_write(OFF_OFFSET_CH1, 24'hfffffb);
    reg_write(OFF_GAIN_CH0, 24'h400000);
    reg_write(OFF_GAIN_CH1, 24'h7fffff);
    reg_write(OFF_REF_TRIM, 24'h00005a);
    reg_write(8'h30, 24'habcdef);
    check_reg(OFF_REF_TRIM, 24'h00005a, "ref trim");
    check_reg(8'h30, 24'h000000, "unmapped");
    foreach (rows[i]) begin
      reg_write(OFF_CTRL, {22'h0, rows[i].ctrl});
      send(rows[i].ch, rows[i].raw, lat);
      check("latency", 25'(3 + (rows[i].ctrl[1] ? GAIN_DELAY_CYC : 0)), 25'(lat));
      check("code", {rows[i].ch, rows[i].exp}, {out_chan, out_data});
    end
    check_reg(OFF_OFFSET_CH1, 24'hfffffb, "offset ch1 kept");
    check_reg(OFF_GAIN_CH1, 24'h7fffff, "gain ch1 kept");
    // Both channels in one cycle: consumer stalls so both samples stay visible in turn
    reg_write(OFF_CTRL, 24'h000001);
    @(posedge core_clk);
    req0 <= 1'b1;
    req1 <= 1'b1;
    code0 <= 24'h000010;
    code1 <= 24'h000010;
    out_ready <= 1'b0;
    @(posedge core_clk);
    req0 <= 1'b0;
    req1 <= 1'b0;
    repeat (10) @(posedge core_clk);
    check("pair first", 25'h0000013, {out_chan, out_data});
    out_ready <= 1'b1;
    repeat (2) @(posedge core_clk);
    check("pair second", 25'h100000b, {out_chan, out_data});
    check_reg(OFF_STATUS, 24'h000000, "no drop");
    // Fill while the consumer stalls, then drain with a stuttering ready
    reg_write(OFF_CTRL, 24'h000000);
    got_q.delete();
    for (int i = 0; i < 20; i++) begin
      @(posedge core_clk);
      out_ready <= 1'b0;
      req0 <= 1'b1;
      code0 <= 24'(i);
      @(posedge core_clk);
      req0 <= 1'b0;
    end
    check("drop flag", 25'h1, {24'h0, drop_q});
    check_reg(OFF_STATUS, 24'h000001, "status drop");
    check_reg(OFF_STATUS, 24'h000000, "status cleared");
    collect(60);
    // Output register holds one sample beside the full FIFO
    check("fifo count", 25'(FIFO_DEPTH + 1), 25'(got_q.size()));
    for (int k = 0; k < 16; k++) check("fifo order", 25'(k), got_q[k]);
    // A second reset in mid-run restores every register
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    check_resets();
    stop_test();
  end
endmodule : tb
